// [verilog/mie_pkg.sv]
// package: opcodes, widths and reset values for the instruction subset unit
package mie_pkg;
	// 14-bit instruction encodings (mask/match pairs)
	localparam logic [13:0] OP_WDT_CLR    = 14'h0064;
	localparam logic [13:0] OP_ACC_CLR_M  = 14'h3f80;
	localparam logic [13:0] OP_ACC_CLR    = 14'h0100;
	localparam logic [13:0] OP_FILE_CLR_M = 14'h3f80;
	localparam logic [13:0] OP_FILE_CLR   = 14'h0180;
	localparam logic [13:0] OP_FOP_M      = 14'h3f00;
	localparam logic [13:0] OP_FILE_DEC   = 14'h0300;
	localparam logic [13:0] OP_FILE_COMP  = 14'h0900;
	localparam logic [13:0] OP_DEC_SKIP   = 14'h0b00;
	localparam logic [13:0] OP_CALL_M     = 14'h3800;
	localparam logic [13:0] OP_CALL       = 14'h2000;
	// field positions
	localparam int DEST_BIT   = 7;
	localparam int FADDR_W    = 7;
	localparam int KADDR_W    = 11;
	localparam int LATCH_HI   = 4;
	localparam int LATCH_LO   = 3;
	// widths and reset values
	localparam int PC_W       = 13;
	localparam int WDT_W      = 8;
	localparam int PRE_W      = 8;
	localparam logic [7:0] WDT_CLR_VAL = 8'h00;
	localparam logic [7:0] PRE_CLR_VAL = 8'h00;
	localparam logic [7:0] ACC_RST     = 8'h00;
	localparam logic [12:0] PC_RST     = 13'h0000;
	localparam int STACK_D    = 8;
	localparam int SP_W       = 3;
endpackage : mie_pkg

// [verilog/mie_exec.sv]
// execution unit for the watchdog clear, call and file-register subset
//
// Operation
// - watchdog clear loads the watchdog counter and its prescaler with zero.
// - watchdog clear sets timeout_flag_n and powerdown_flag_n to one only.
// - a call pushes pc plus one onto stack_top first.
// - a call loads k into pc[10:0] and pc_high_latch[4:3] into pc[12:11].
// - a call takes two cycles and leaves every status flag as it was.
// - complement writes the inverse of the file register and updates zero.
// - destination bit 0 selects the accumulator, 1 the file register.
// - file clear writes zero to the file register and sets zero.
// - accumulator clear writes zero to the accumulator and sets zero.
// - decrement writes file minus one to the destination, updates zero.
// - decrement-skip stores the result, skips on zero, touches no flags.
//
// notes for the next engineer
// the unit sits behind the fetch stage and sees one instruction word per
// issue, beside the current content of the addressed file register, which
// the core reads from its register file in the same cycle.
// every result is flopped: accumulator, zero flag, program counter, the
// watchdog pair and the file write port all change on the edge that
// takes the instruction, so the core sees them one cycle later.
// a call or a taken skip leaves a flush cycle behind it. busy is high for
// exactly that cycle and whatever is offered then is dropped, so the fetch
// stage must hold or replay the word itself; this keeps the unit free of
// any instruction buffer at the cost of one lost slot per branch.
// words outside the subset only step the program counter by one, which
// lets the unit sit beside a fuller decoder that handles the rest.
// the file write port is one strobe wide; address and data follow the
// decoded word every cycle and mean something only beside the strobe.
// the return stack is circular: a ninth call overwrites the oldest entry
// without warning, as the core has no overflow flag to raise.
// the stack storage has no reset; an entry is only ever read after it was
// pushed, and leaving it unreset saves a wide reset fan-out.
// the watchdog counter and its prescaler only count here; the timeout
// decision and the sleep logic that would clear the status flags live in
// the core, so both active-low flags stay high in this block.
// a watchdog clear in the same cycle as a tick wins, so software that
// clears right on a tick never sees the counter step past zero.
// decrement-skip writes its result like a plain decrement but leaves the
// zero flag alone; only the program counter and busy tell a skip happened.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
module mie_exec #(
	parameter int WDT_W = mie_pkg::WDT_W,
	parameter int PRE_W = mie_pkg::PRE_W
) (
	// clock and reset
	input  wire logic                     mclk,
	input  wire logic                     srst,
	// instruction issue
	input  wire logic                     instr_valid,
	input  wire logic [13:0]              instr,
	input  wire logic [7:0]               file_rdata,
	input  wire logic [7:0]               pc_high_latch,
	// watchdog advance from the core
	input  wire logic                     wdt_tick,
	// file register write port
	output logic                          file_we,
	output logic [6:0]                    file_waddr,
	output logic [7:0]                    file_wdata,
	// core state
	output logic [7:0]                    acc,
	output logic                          zero_flag,
	output logic                          timeout_flag_n,
	output logic                          powerdown_flag_n,
	output logic [WDT_W-1:0]              watchdog_counter,
	output logic [PRE_W-1:0]              wdt_prescaler,
	output logic [mie_pkg::PC_W-1:0]      pc,
	output logic [mie_pkg::PC_W-1:0]      stack_top,
	output logic                          busy
);
	typedef enum logic [0:0] {MIE_EXEC, MIE_FLUSH} mie_state_t;

	// mask and match test shared by every opcode class except watchdog clear, which compares the whole word
	// the classes never overlap, so the order of tests does not matter
	function automatic logic op_is(input logic [13:0] ins,
		input logic [13:0] msk, input logic [13:0] val);
		op_is = (ins & msk) == val;
	endfunction : op_is

	// sequencing
	mie_state_t               state_ff, nxt_state;
	logic                     busy_ff;
	// accumulator and zero flag
	logic [7:0]               acc_ff, nxt_acc;
	logic                     zero_ff, nxt_zero;
	// status flags, active low
	logic                     to_n_ff;
	logic                     pd_n_ff;
	// watchdog
	logic [WDT_W-1:0]         wdt_ff;
	logic [PRE_W-1:0]         pre_ff;
	// program counter and return stack
	logic [mie_pkg::PC_W-1:0] pc_ff, nxt_pc;
	logic [mie_pkg::PC_W-1:0] stack_mem [mie_pkg::STACK_D];
	logic [mie_pkg::SP_W-1:0] sp_ff;
	logic [mie_pkg::PC_W-1:0] tos_ff;
	// file register write port
	logic                     fwe_ff;
	logic [6:0]               fwa_ff;
	logic [7:0]               fwd_ff;

	// an instruction counts only while no flush cycle is pending
	wire issue     = instr_valid && state_ff == MIE_EXEC;
	// watchdog clear is one fixed word with no operand
	wire is_wdt    = issue && instr == mie_pkg::OP_WDT_CLR;
	// accumulator clear, low bits ignored
	wire is_aclr   = issue && op_is(instr, mie_pkg::OP_ACC_CLR_M,
		mie_pkg::OP_ACC_CLR);
	// file clear, address in the low seven bits
	wire is_fclr   = issue && op_is(instr, mie_pkg::OP_FILE_CLR_M,
		mie_pkg::OP_FILE_CLR);
	// decrement, complement and decrement-skip share one byte layout
	wire is_dec    = issue && op_is(instr, mie_pkg::OP_FOP_M,
		mie_pkg::OP_FILE_DEC);
	wire is_comp   = issue && op_is(instr, mie_pkg::OP_FOP_M,
		mie_pkg::OP_FILE_COMP);
	wire is_dskip  = issue && op_is(instr, mie_pkg::OP_FOP_M,
		mie_pkg::OP_DEC_SKIP);
	// call carries an eleven-bit target
	wire is_call   = issue && op_is(instr, mie_pkg::OP_CALL_M,
		mie_pkg::OP_CALL);
	// operand fields; meaningless for words that do not use them
	wire dest_file = instr[mie_pkg::DEST_BIT];
	wire [6:0] faddr = instr[mie_pkg::FADDR_W-1:0];

	// datapath results
	wire [7:0] dec_res  = file_rdata - 8'h01;
	wire [7:0] comp_res = ~file_rdata;
	wire [7:0] fop_res  = is_comp ? comp_res : dec_res;
	wire       fop_any  = is_dec || is_comp || is_dskip;
	wire       skip_hit = is_dskip && dec_res == 8'h00;
	wire [mie_pkg::PC_W-1:0] pc_inc = pc_ff + 13'h0001;
	// a taken skip steps over the discarded word
	wire [mie_pkg::PC_W-1:0] pc_skip = pc_ff + 13'h0002;
	wire [mie_pkg::PC_W-1:0] call_tgt = {
		pc_high_latch[mie_pkg::LATCH_HI:mie_pkg::LATCH_LO],
		instr[mie_pkg::KADDR_W-1:0]};

	// next accumulator and zero flag
	always_comb begin
		nxt_acc  = acc_ff;
		nxt_zero = zero_ff;
		// defaults hold; call and watchdog clear fall through untouched
		if (is_aclr) begin
			nxt_acc  = mie_pkg::ACC_RST;
			nxt_zero = 1'b1;
		end else if (is_fclr) begin
			nxt_zero = 1'b1;
		end else if (fop_any) begin
			if (!dest_file)
				nxt_acc = fop_res;
			// skip form leaves the flag alone
			if (!is_dskip)
				nxt_zero = fop_res == 8'h00;
		end
	end

	// sequencing: call and taken skip spend a flush cycle
	always_comb begin
		nxt_state = MIE_EXEC;
		nxt_pc    = pc_ff;
		case (state_ff)
			MIE_EXEC: begin
				if (is_call) begin
					nxt_pc    = call_tgt;
					nxt_state = MIE_FLUSH;
				end else if (skip_hit) begin
					nxt_pc    = pc_skip;
					nxt_state = MIE_FLUSH;
				end else if (issue) begin
					nxt_pc    = pc_inc;
				end
			end
			// the flush slot drops the word after a call or taken skip
			MIE_FLUSH: nxt_state = MIE_EXEC;
			default:   nxt_state = MIE_EXEC;
		endcase
	end

	// control state; the flush cycle swallows whatever is offered
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_ff <= MIE_EXEC;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// busy is its own flop so the port never sees the state decode
	always_ff @(posedge mclk) begin
		if (srst) begin
			busy_ff <= 1'b0;
		end else begin
			busy_ff <= nxt_state == MIE_FLUSH;
		end
	end

	// accumulator, written at the end of the issuing cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			acc_ff <= mie_pkg::ACC_RST;
		end else begin
			acc_ff <= nxt_acc;
		end
	end

	// zero flag; a call never reaches the update terms
	always_ff @(posedge mclk) begin
		if (srst) begin
			zero_ff <= 1'b0;
		end else begin
			zero_ff <= nxt_zero;
		end
	end

	// program counter
	always_ff @(posedge mclk) begin
		if (srst) begin
			pc_ff <= mie_pkg::PC_RST;
		end else begin
			pc_ff <= nxt_pc;
		end
	end

	// status flags: cleared power-on values are one, watchdog clear restores
	always_ff @(posedge mclk) begin
		if (srst) begin
			to_n_ff <= 1'b1;
			pd_n_ff <= 1'b1;
		end else if (is_wdt) begin
			to_n_ff <= 1'b1;
			pd_n_ff <= 1'b1;
		end
	end

	// watchdog advance terms; the prescaler carries into the counter
	// only on its wrap, so the counter moves once per prescaler period
	wire                 pre_wrap = wdt_tick && &pre_ff;
	wire [PRE_W-1:0]     nxt_pre  = wdt_tick ? pre_ff + PRE_W'(1) : pre_ff;
	wire [WDT_W-1:0]     nxt_wdt  = pre_wrap ? wdt_ff + WDT_W'(1) : wdt_ff;

	// watchdog prescaler; clear beats a coincident tick
	always_ff @(posedge mclk) begin
		if (srst || is_wdt) begin
			pre_ff <= PRE_W'(mie_pkg::PRE_CLR_VAL);
		end else begin
			pre_ff <= nxt_pre;
		end
	end

	// watchdog counter; same priority as the prescaler
	always_ff @(posedge mclk) begin
		if (srst || is_wdt) begin
			wdt_ff <= WDT_W'(mie_pkg::WDT_CLR_VAL);
		end else begin
			wdt_ff <= nxt_wdt;
		end
	end

	// next free stack slot; circular, overflow silently wraps
	wire [mie_pkg::SP_W-1:0] nxt_sp = sp_ff + mie_pkg::SP_W'(1);

	// stack pointer
	always_ff @(posedge mclk) begin
		if (srst) begin
			sp_ff <= '0;
		end else if (is_call) begin
			sp_ff <= nxt_sp;
		end
	end

	// stack storage; no reset, an entry is only read after its push
	always_ff @(posedge mclk) begin
		if (is_call) begin
			stack_mem[nxt_sp] <= pc_inc;
		end
	end

	// file write strobe, registered so it lands at cycle end
	always_ff @(posedge mclk) begin
		if (srst) begin
			fwe_ff <= 1'b0;
		end else begin
			fwe_ff <= is_fclr || (fop_any && dest_file);
		end
	end

	// file write address; only meaningful beside the strobe
	always_ff @(posedge mclk) begin
		if (srst) begin
			fwa_ff <= 7'h00;
		end else begin
			fwa_ff <= faddr;
		end
	end

	// file write data; clear forces zero, the rest take the alu result
	always_ff @(posedge mclk) begin
		if (srst) begin
			fwd_ff <= 8'h00;
		end else begin
			fwd_ff <= is_fclr ? 8'h00 : fop_res;
		end
	end

	// stack top mirror, flopped so the output stays registered
	always_ff @(posedge mclk) begin
		if (srst)
			tos_ff <= mie_pkg::PC_RST;
		else if (is_call)
			tos_ff <= pc_inc;
	end

	// file write port
	assign file_we          = fwe_ff;
	assign file_waddr       = fwa_ff;
	assign file_wdata       = fwd_ff;
	// working register and flags
	assign acc              = acc_ff;
	assign zero_flag        = zero_ff;
	assign timeout_flag_n   = to_n_ff;
	assign powerdown_flag_n = pd_n_ff;
	// watchdog
	assign watchdog_counter = wdt_ff;
	assign wdt_prescaler    = pre_ff;
	// sequencing
	assign pc               = pc_ff;
	assign stack_top        = tos_ff;
	assign busy             = busy_ff;
endmodule : mie_exec

// [sim/mie_exec_checker.sv]
// checker: port assertions for the instruction subset unit
`timescale 1ns/1ps
module mie_exec_checker #(
	parameter int WDT_W = 8,
	parameter int PRE_W = 8
) (
	// clock, reset and issue
	input wire logic             mclk,
	input wire logic             srst,
	input wire logic             instr_valid,
	input wire logic [13:0]      instr,
	input wire logic [7:0]       file_rdata,
	input wire logic [7:0]       pc_high_latch,
	// results
	input wire logic             file_we,
	input wire logic [7:0]       file_wdata,
	input wire logic [7:0]       acc,
	input wire logic             zero_flag,
	input wire logic             timeout_flag_n,
	input wire logic             powerdown_flag_n,
	input wire logic [WDT_W-1:0] watchdog_counter,
	input wire logic [PRE_W-1:0] wdt_prescaler,
	input wire logic [12:0]      pc,
	input wire logic [12:0]      stack_top,
	input wire logic             busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// an issue counts only while the unit is free
	wire        take = instr_valid && !busy;
	wire [5:0]  opc  = instr[13:8];
	wire        call = take && instr[13:11] == 3'b100;
	wire [1:0]  lat  = pc_high_latch[4:3];
	wire [10:0] kadr = instr[10:0];
	chk_wdt_zero: assert property (take && instr == 14'h0064 |=>
		watchdog_counter == '0 && wdt_prescaler == '0) else $error("wdt");
	chk_wdt_flags: assert property (take && instr == 14'h0064 |=>
		timeout_flag_n && powerdown_flag_n && $stable(zero_flag))
		else $error("wdt flags");
	chk_call_push: assert property (call |=>
		stack_top == $past(pc) + 13'h1) else $error("push");
	chk_call_dest: assert property (call |=>
		pc == {$past(lat), $past(kadr)}) else $error("call target");
	chk_call_two: assert property (call |=>
		busy && $stable(zero_flag) ##1 !busy) else $error("call cycles");
	chk_comp_file: assert property (take && opc == 6'h09 &&
		instr[7] |=> file_we && file_wdata == ~$past(file_rdata))
		else $error("comp");
	chk_clear_zero: assert property (take && opc == 6'h01 |=>
		zero_flag && (file_we ? file_wdata == 8'h00 : acc == 8'h00))
		else $error("clear");
	chk_single_cycle: assert property (take && !call && opc != 6'h0b |=>
		!busy && pc == $past(pc) + 13'h1) else $error("one cycle");
	chk_dec_acc: assert property (take && opc == 6'h03 && !instr[7] |=>
		acc == $past(file_rdata) - 8'h01 && !file_we) else $error("dec");
	chk_skip_flag: assert property (take && opc == 6'h0b |=>
		$stable(zero_flag)) else $error("skip flag");
endmodule : mie_exec_checker

bind mie_exec mie_exec_checker #(.WDT_W(WDT_W), .PRE_W(PRE_W)) u_chk (.*);

// [sim/testbench.sv]
// testbench: directed and random runs of the instruction subset unit
`timescale 1ns/1ps
module testbench;
	logic        mclk = 0, srst = 1, instr_valid = 0, wdt_tick = 0;
	logic [13:0] instr = '0;
	logic [7:0]  file_rdata = '0, pc_high_latch = '0;
	logic        file_we, zero_flag, timeout_flag_n, powerdown_flag_n, busy;
	logic [6:0]  file_waddr;
	logic [7:0]  file_wdata, acc, watchdog_counter, wdt_prescaler, e_acc = '0;
	logic [12:0] pc, stack_top, e_pc = '0, e_top = '0;
	logic        e_z = 0;
	int          mismatches = 0, compares = 0, seed = 32'h08e9551f;
	logic [13:0] base [7] = '{14'h0064, 14'h0100, 14'h0180, 14'h0300,
		14'h0900, 14'h0b00, 14'h2000};
	logic [13:0] msk [7] = '{14'h0000, 14'h007f, 14'h007f, 14'h00ff,
		14'h00ff, 14'h00ff, 14'h07ff};
	mie_exec u_mie_exec (.*);
	// 125 mhz clock; random ticks keep the watchdog moving under a clear
	always #4 mclk = ~mclk;
	always @(posedge mclk) wdt_tick <= $random(seed);
	// expected value written by a file or accumulator operation
	function automatic logic [7:0] res(input logic [13:0] i,
		input logic [7:0] f);
		case (i[13:8])
			6'h09: res = ~f;
			6'h03, 6'h0b: res = f - 8'h01;
			default: res = 8'h00;
		endcase
	endfunction : res
	task automatic chk(input logic ok);
		compares++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("Error %0t: output mismatch", $time);
		end
	endtask : chk
	task automatic finish_test();
		if (mismatches == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// issue one instruction, then compare every result a cycle later
	task automatic op(input logic [13:0] i, input logic [7:0] f);
		logic [7:0] r, lat;
		logic       fop, call, wr, sk;
		lat = $random(seed);
		r = res(i, f);
		call = i[13:11] == 3'b100;
		fop = i[13:8] inside {6'h01, 6'h03, 6'h09, 6'h0b};
		wr = fop && i[7];
		sk = i[13:8] == 6'h0b && r == 8'h00;
		@(posedge mclk);
		instr <= i;
		instr_valid <= 1'b1;
		file_rdata <= f;
		pc_high_latch <= lat;
		@(posedge mclk);
		// offer an accumulator clear in the flush slot; it must be dropped
		instr_valid <= call || sk;
		instr <= (call || sk) ? 14'h0100 : i;
		file_rdata <= ~f; // stale data must not leak into a later op
		#1;
		if (call) begin
			e_top = e_pc + 13'h1;
			e_pc = {lat[4:3], i[10:0]};
		end else
			e_pc = e_pc + (sk ? 13'h2 : 13'h1);
		if (fop && !i[7]) e_acc = r;
		if (fop && i[13:8] != 6'h0b) e_z = r == 8'h00;
		chk(pc === e_pc && stack_top === e_top);
		chk(acc === e_acc && zero_flag === e_z);
		chk(file_we === wr && (!wr || file_wdata === r));
		chk(!wr || file_waddr === i[6:0]);
		chk(busy === (call || sk));
		if (i == 14'h0064) begin
			chk(watchdog_counter === 8'h00 && wdt_prescaler === 8'h00);
			chk(timeout_flag_n === 1'b1 && powerdown_flag_n === 1'b1);
		end
	endtask : op
	// corner cases first, then a seeded random mix
	initial begin
		int k;
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		op(14'h0064, 8'h00);
		op(14'h27ff, 8'h00);
		op(14'h0985, 8'hff);
		op(14'h0900, 8'h5a);
		op(14'h0185, 8'h33);
		op(14'h017f, 8'h12);
		op(14'h0300, 8'h01);
		op(14'h0380, 8'h00);
		op(14'h0b80, 8'h01);
		op(14'h0b00, 8'h02);
		for (int n = 0; n < 300; n++) begin
			k = {$random(seed)} % 7;
			op(base[k] | (14'($random(seed)) & msk[k]), 8'($random(seed)));
		end
		finish_test();
	end
	// hang guard, well past the roughly 625 cycles the run needs
	initial begin
		repeat (5000) @(posedge mclk);
		mismatches++;
		finish_test();
	end
endmodule : testbench
